// file: tmr_map.vh
// Register offsets, field positions, reset values and codes for the 16-bit timer/event counter.
// Assumes an APB slave with 32-bit data, one aligned word per register.
//
// Contract
// [RULE_01] Interval mode: on match clear counter, keep counting, pulse match request.
// [RULE_02] Match interval is compare value plus one count-clock periods, 0001H to FFFFH.
// [RULE_03] In clear-on-match operation overflow sets only when compare holds FFFFH. The code also sets it whenever the count wraps past a lowered compare.
// [RULE_04] Compare lowered below count: counter runs on, wraps, restarts before matching.
// [RULE_05] Software restarts the timer after lowering the compare value while running.
// [RULE_06] Count clock selected by prescaler config bits 1 and 0.
// [RULE_07] Software sets capture control, compare, count clock, then mode register last.
// [RULE_08] Event mode increments once per qualified valid primary input edge.
// [RULE_09] Event mode: on match clear counter and pulse match request.
// [RULE_10] Software loads a nonzero compare value in event counter mode.
// [RULE_11] Primary edge sensitivity chosen by prescaler config bits 5 and 4.
// [RULE_12] Event input sampled on system clock; edge needs valid level twice.
// [RULE_13] After start, counting begins only after a twice-detected valid edge.
// [RULE_14] Software reads the running counter, not the compare register, for events.
// [RULE_15] Capture inputs sampled at count clock; capture after valid level seen twice. The code samples them every system clock when counting primary edges.
// [RULE_16] Free-running, primary edge copies count into capture b and pulses its request.
// [RULE_17] Secondary edge, bits 7 and 6, copies count into capture a, pulses request.
// [RULE_18] Free-running pulse widths are valid only up to one counter period.
// [RULE_19] Edge field: 00 falling, 01 rising, 11 both, 10 prohibited.
// [RULE_20] Clock field: 00 system, 01 divide by 4, 10 divide by 256, 11 primary edges.
// [RULE_21] Each match or capture request is one pulse synchronous to the count clock.
`ifndef TMR_MAP_VH
`define TMR_MAP_VH

// Register byte offsets.
`define OFS_UP_COUNTER 12'h000
`define OFS_CMP_CAP_A 12'h004
`define OFS_CMP_CAP_B 12'h008
`define OFS_CAP_CMP_CTRL 12'h00C
`define OFS_PRESCALER_CFG 12'h010
`define OFS_MODE_CTRL 12'h014

// Reset values.
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

// Prescaler config fields.
`define CLK_SEL_LSB 0
`define PRI_EDGE_LSB 4
`define SEC_EDGE_LSB 6

// Count clock codes.
`define CLK_SYS 2'h0
`define CLK_DIV4 2'h1
`define CLK_DIV256 2'h2
`define CLK_PRI_EDGE 2'h3

// Edge select codes.
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h3

// Prescaler divide terminal counts.
`define DIV4_LAST 8'h03
`define DIV256_LAST 8'hFF

// Mode control fields: bits 3..2 operating mode, bit 0 overflow flag.
`define MODE_LSB 2
`define MODE_STOP 2'h0
`define MODE_FREE 2'h1
`define MODE_CLEAR 2'h3
`define OVF_BIT 0

// Capture control: bit 0 makes register a capture register, bit 2 enables capture b.
`define CAPA_EN_BIT 0
`define CAPB_EN_BIT 2

`define CNT_MAX 16'hFFFF

`endif

// file: edge_qualifier.v
// Two-sample edge qualifier for one timer input pin.
// Assumes the pin is already synchronous to clk_sys_in; sample_in marks the sampling instants.
`include "tmr_map.vh"

module edge_qualifier (
    // Clock and reset.
    input wire clk_sys_in,
    input wire reset_in,
    // Control.
    input wire clear_in,
    input wire sample_in,
    input wire [1:0] edge_sel_in,
    // Pin and result.
    input wire pin_in,
    output reg edge_out
);

    reg sample_reg;
    reg level_reg;

    // A level is accepted only when two successive samples agree, so short glitches vanish.
    // While cleared the accepted level rests low, so a high pin after start reads as a rising edge.
    always @(posedge clk_sys_in) begin
        if (reset_in || clear_in) begin
            sample_reg <= 1'b0;
            level_reg <= 1'b0;
            edge_out <= 1'b0;
        end else begin
            edge_out <= 1'b0;
            if (sample_in) begin
                sample_reg <= pin_in;
                if (pin_in == sample_reg && pin_in != level_reg) begin // see [RULE_12] see [RULE_15]
                    level_reg <= pin_in;
                    case (edge_sel_in) // see [RULE_19]
                        `EDGE_FALL: edge_out <= ~pin_in;
                        `EDGE_RISE: edge_out <= pin_in;
                        `EDGE_BOTH: edge_out <= 1'b1;
                        default: edge_out <= 1'b0;
                    endcase
                end
            end
        end
    end

endmodule // edge_qualifier

// file: timer_event_counter_capture.v
// 16-bit timer/event counter with interval, event counting and capture modes.
// Assumes an APB master on the register side and edge inputs synchronous to clk_sys_in.
`include "tmr_map.vh"

module timer_event_counter_capture (
    // Clock and reset.
    input wire clk_sys_in,
    input wire reset_in,
    // APB slave.
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // Edge inputs.
    input wire edge_input_primary_in,
    input wire edge_input_secondary_in,
    // Interrupt request pulses.
    output reg irq_match_a_out,
    output reg irq_capture_b_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    reg [15:0] up_counter_reg;
    reg [15:0] compare_capture_a_reg;
    reg [15:0] compare_capture_b_reg;
    reg [7:0] capture_compare_control_reg;
    reg [7:0] prescaler_config_reg;
    reg [7:0] timer_mode_control_reg;
    reg [7:0] div_reg;
    reg tick_reg;

    wire [1:0] clk_sel = prescaler_config_reg[`CLK_SEL_LSB+1:`CLK_SEL_LSB];
    wire [1:0] mode = timer_mode_control_reg[`MODE_LSB+1:`MODE_LSB];
    wire running = (mode != `MODE_STOP);
    wire clear_mode = (mode == `MODE_CLEAR);
    wire cap_a_en = capture_compare_control_reg[`CAPA_EN_BIT];
    wire cap_b_en = capture_compare_control_reg[`CAPB_EN_BIT];

    // Address decode helper, used by both the write commit and the error answer.
    function mapped;
        input [11:0] addr;
        begin
            if (addr == `OFS_UP_COUNTER) mapped = 1'b1;
            else if (addr == `OFS_CMP_CAP_A) mapped = 1'b1;
            else if (addr == `OFS_CMP_CAP_B) mapped = 1'b1;
            else if (addr == `OFS_CAP_CMP_CTRL) mapped = 1'b1;
            else if (addr == `OFS_PRESCALER_CFG) mapped = 1'b1;
            else if (addr == `OFS_MODE_CTRL) mapped = 1'b1;
            else mapped = 1'b0;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait state, writes land at the edge that sees pready high.

    wire access = psel_in && penable_in;
    wire wr_commit = access && pready_out && pwrite_in && mapped(paddr_in);

    reg [31:0] rdata;

    // Read multiplexer; unmapped addresses read zero.
    always @* begin
        rdata = 32'h0000_0000;
        if (paddr_in == `OFS_UP_COUNTER) rdata = {16'h0000, up_counter_reg}; // see [RULE_14]
        else if (paddr_in == `OFS_CMP_CAP_A) rdata = {16'h0000, compare_capture_a_reg};
        else if (paddr_in == `OFS_CMP_CAP_B) rdata = {16'h0000, compare_capture_b_reg};
        else if (paddr_in == `OFS_CAP_CMP_CTRL) rdata = {24'h000000, capture_compare_control_reg};
        else if (paddr_in == `OFS_PRESCALER_CFG) rdata = {24'h000000, prescaler_config_reg};
        else if (paddr_in == `OFS_MODE_CTRL) rdata = {24'h000000, timer_mode_control_reg};
    end

    // Answer flops; pready drops after each completed access so every transfer sees one wait.
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= access && !pready_out;
            prdata_out <= (access && !pready_out && !pwrite_in) ? rdata : 32'h0000_0000;
            pslverr_out <= access && !pready_out && !mapped(paddr_in);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count clock generation.

    // The prescaler runs only while the timer runs so each start has a clean phase.
    always @(posedge clk_sys_in) begin
        if (reset_in || !running) begin
            div_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 8'h01;
            case (clk_sel) // see [RULE_06] see [RULE_20]
                `CLK_SYS: tick_reg <= 1'b1;
                `CLK_DIV4: tick_reg <= ({6'h00, div_reg[1:0]} == `DIV4_LAST);
                `CLK_DIV256: tick_reg <= (div_reg == `DIV256_LAST);
                default: tick_reg <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input qualification.

    wire pri_count_edge;
    wire pri_cap_edge;
    wire sec_cap_edge;
    // Event counting samples every system clock; captures sample at the count clock, or every system clock when counting primary edges.
    wire cap_sample = (clk_sel == `CLK_PRI_EDGE) ? 1'b1 : tick_reg;

    // Event counting filter: a stopped timer clears it, so counting waits for a qualified edge.
    edge_qualifier u_pri_count (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .clear_in(!running || clk_sel != `CLK_PRI_EDGE),
        .sample_in(1'b1), // see [RULE_12] see [RULE_13]
        .edge_sel_in(prescaler_config_reg[`PRI_EDGE_LSB+1:`PRI_EDGE_LSB]), // see [RULE_11]
        .pin_in(edge_input_primary_in),
        .edge_out(pri_count_edge)
    );

    // Primary capture filter, sampled at the count clock, or every system clock when counting primary edges.
    edge_qualifier u_pri_cap (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .clear_in(!running),
        .sample_in(cap_sample), // see [RULE_15]
        .edge_sel_in(prescaler_config_reg[`PRI_EDGE_LSB+1:`PRI_EDGE_LSB]),
        .pin_in(edge_input_primary_in),
        .edge_out(pri_cap_edge)
    );

    // Secondary capture filter.
    edge_qualifier u_sec_cap (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .clear_in(!running),
        .sample_in(cap_sample), // see [RULE_15]
        .edge_sel_in(prescaler_config_reg[`SEC_EDGE_LSB+1:`SEC_EDGE_LSB]), // see [RULE_17]
        .pin_in(edge_input_secondary_in),
        .edge_out(sec_cap_edge)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Counter, match, capture and control registers.

    wire count_tick = (clk_sel == `CLK_PRI_EDGE) ? pri_count_edge : tick_reg; // see [RULE_08]
    // Match only while compare_capture_a acts as compare; a capture register never clears.
    wire match = clear_mode && !cap_a_en && (up_counter_reg == compare_capture_a_reg);
    wire wrap = (up_counter_reg == `CNT_MAX);

    // Hardware events take priority over a software write in the same cycle.
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            up_counter_reg <= `RST_WORD;
            compare_capture_a_reg <= `RST_WORD;
            compare_capture_b_reg <= `RST_WORD;
            capture_compare_control_reg <= `RST_BYTE;
            prescaler_config_reg <= `RST_BYTE;
            timer_mode_control_reg <= `RST_BYTE;
            irq_match_a_out <= 1'b0;
            irq_capture_b_out <= 1'b0;
        end else begin
            irq_match_a_out <= 1'b0;
            irq_capture_b_out <= 1'b0;
            // Software writes first, so the hardware assignments below override them.
            if (wr_commit) begin
                if (paddr_in == `OFS_CMP_CAP_A) compare_capture_a_reg <= pwdata_in[15:0];
                else if (paddr_in == `OFS_CMP_CAP_B) compare_capture_b_reg <= pwdata_in[15:0];
                else if (paddr_in == `OFS_CAP_CMP_CTRL) capture_compare_control_reg <= pwdata_in[7:0];
                else if (paddr_in == `OFS_PRESCALER_CFG) prescaler_config_reg <= pwdata_in[7:0];
                else if (paddr_in == `OFS_MODE_CTRL) timer_mode_control_reg <= pwdata_in[7:0];
            end
            if (!running) begin
                up_counter_reg <= `RST_WORD;
            end else if (count_tick) begin
                if (match) begin
                    up_counter_reg <= `RST_WORD; // see [RULE_01] see [RULE_09] see [RULE_02]
                    irq_match_a_out <= 1'b1; // see [RULE_21]
                end else begin
                    // A compare below the count is passed by; the count wraps first.
                    up_counter_reg <= up_counter_reg + 16'h0001; // see [RULE_04]
                end
                // In clear mode the count reaches FFFFH when compare is FFFFH or was lowered below the count.
                if (wrap) begin
                    timer_mode_control_reg[`OVF_BIT] <= 1'b1; // see [RULE_03]
                end
            end
            if (running && pri_cap_edge && cap_b_en) begin
                compare_capture_b_reg <= up_counter_reg; // see [RULE_16]
                irq_capture_b_out <= 1'b1; // see [RULE_21]
            end
            if (running && sec_cap_edge && cap_a_en) begin
                compare_capture_a_reg <= up_counter_reg; // see [RULE_17]
                irq_match_a_out <= 1'b1;
            end
        end
    end

endmodule // timer_event_counter_capture

// file: tmr_assertions.sv
// Port checks for the timer block: APB answer timing and request pulses.
// Assumes it is bound into the timer top module and shares its one clock.
module tmr_assertions (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // APB.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Requests.
    input wire logic irq_match_a_out,
    input wire logic irq_capture_b_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////////////////////////
    // A transfer opens with a setup cycle and then its first access cycle.
    sequence s_access;
        psel_in && !penable_in ##1 psel_in && penable_in;
    endsequence
    sequence s_bad_access;
        psel_in && !penable_in && paddr_in > 12'h017 ##1 psel_in && penable_in;
    endsequence
    a_ready_after_access: assert property (s_access |=> pready_out)
        else $error("no answer after access");
    a_ready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("answer held too long");
    a_error_when_unmapped: assert property (s_bad_access |=> pready_out && pslverr_out)
        else $error("unmapped access not refused");
    a_error_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without answer");
    a_data_idle_zero: assert property (!pready_out |-> prdata_out == 32'h00000000)
        else $error("read data outside answer");
    a_match_single_pulse: assert property (irq_match_a_out |=> !irq_match_a_out)
        else $error("match request longer than one cycle");
    a_capture_single_pulse: assert property (irq_capture_b_out |=> !irq_capture_b_out)
        else $error("capture request longer than one cycle");
    a_quiet_after_reset: assert property ($past(reset_in) |-> !pready_out && !irq_match_a_out && !irq_capture_b_out)
        else $error("output active after reset");
endmodule // tmr_assertions

bind timer_event_counter_capture tmr_assertions u_tmr_assertions (.clk_sys_in, .reset_in, .psel_in,
    .penable_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out, .irq_match_a_out, .irq_capture_b_out);

// file: pulse_source.sv
// Behavioural external pulse source for one timer edge input.
// Assumes go_in is a one-cycle request; the pin idles low between bursts.
module pulse_source (
    // Clock and request.
    input wire logic clk_sys_in,
    input wire logic go_in,
    input wire logic [7:0] width_in,
    input wire logic [7:0] count_in,
    // Pin.
    output logic pin_out,
    output logic busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Each pulse is high and then low for width cycles, so a width of one is a glitch train.
    initial begin
        pin_out <= 1'b0;
        busy_out <= 1'b0;
        forever begin
            @(posedge clk_sys_in);
            if (go_in) begin
                busy_out <= 1'b1;
                for (int p = 0; p < count_in; p++) begin
                    pin_out <= 1'b1;
                    repeat (width_in) @(posedge clk_sys_in);
                    pin_out <= 1'b0;
                    repeat (width_in) @(posedge clk_sys_in);
                end
                busy_out <= 1'b0;
            end
        end
    end
endmodule // pulse_source

// file: testbench.sv
// Self-checking bench for the timer block: registers, interval, event count and capture.
// Assumes the timer design, its map header and the pulse source are compiled first.
`include "tmr_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rdv;
    logic pready_out, pslverr_out, errv, irq_match_a_out, irq_capture_b_out, pri_pin, sec_pin, pri_busy, sec_busy;
    logic pri_go = 1'b0, sec_go = 1'b0;
    logic [7:0] width = 8'h04, count = 8'h05;
    int mismatches = 0, n_compared = 0, n_irq_a = 0;
    timer_event_counter_capture dut (.clk_sys_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .edge_input_primary_in(pri_pin),
        .edge_input_secondary_in(sec_pin), .irq_match_a_out, .irq_capture_b_out);
    pulse_source pri_src (.clk_sys_in, .go_in(pri_go), .width_in(width), .count_in(count), .pin_out(pri_pin),
        .busy_out(pri_busy));
    pulse_source sec_src (.clk_sys_in, .go_in(sec_go), .width_in(width), .count_in(count), .pin_out(sec_pin),
        .busy_out(sec_busy));
    // Free-running clock at 20 MHz.
    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    // Counting match requests lets a scenario see one it was not waiting for.
    always @(posedge clk_sys_in) n_irq_a <= n_irq_a + 32'(irq_match_a_out === 1'b1);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic give_up();
        $display("BAD wait expected answer seen none");
        mismatches++;
        summarize();
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; the request stays put until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20)
            give_up();
        rdv = prdata_out;
        errv = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    // Edges until the chosen request pulse; b picks the capture b request.
    task automatic wait_irq(input logic b, input int limit, output int n);
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while ((b ? irq_capture_b_out : irq_match_a_out) !== 1'b1 && n < limit);
        if (n >= limit)
            give_up();
    endtask
    // Stop first, then control, compare, clock and mode last, which restarts the timer.
    task automatic start(input logic [7:0] ccc, input logic [15:0] cmp, input logic [7:0] pre, input logic [7:0] m);
        apb(1'b1, `OFS_MODE_CTRL, 32'h0);
        apb(1'b1, `OFS_CAP_CMP_CTRL, 32'(ccc));
        apb(1'b1, `OFS_CMP_CAP_A, 32'(cmp));
        apb(1'b1, `OFS_PRESCALER_CFG, 32'(pre));
        apb(1'b1, `OFS_MODE_CTRL, 32'(m));
    endtask
    task automatic pulse(input logic sec, input logic [7:0] w, input logic [7:0] c);
        @(posedge clk_sys_in);
        width <= w;
        count <= c;
        pri_go <= !sec;
        sec_go <= sec;
        @(posedge clk_sys_in);
        pri_go <= 1'b0;
        sec_go <= 1'b0;
    endtask
    task automatic idle();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while ((pri_busy | sec_busy) !== 1'b0 && n < 2000);
        if (n >= 2000)
            give_up();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_registers();
        for (int a = 0; a < 6; a++) begin
            apb(1'b0, 12'(a * 4), 32'h0);
            check("reset value", 32'h0, rdv);
        end
        apb(1'b1, 12'h018, 32'hFF);
        check("unmapped write error", 32'h1, 32'(errv));
        apb(1'b1, `OFS_PRESCALER_CFG, 32'hF3);
        apb(1'b1, `OFS_UP_COUNTER, 32'h1234);
        apb(1'b0, `OFS_PRESCALER_CFG, 32'h0);
        check("prescaler readback", 32'hF3, rdv);
        apb(1'b0, `OFS_UP_COUNTER, 32'h0);
        check("counter write ignored", 32'h0, rdv);
        $display("registers done");
    endtask
    // Compare 0001H gives a two-tick period, scaled by each divider.
    task automatic t_interval();
        int n;
        int div [3] = '{1, 4, 256};
        for (int i = 0; i < 3; i++) begin
            start(8'h00, 16'h0001, i[7:0], 8'h0C);
            wait_irq(1'b0, 2000, n);
            wait_irq(1'b0, 2000, n);
            check("match period", 32'(2 * div[i]), 32'(n));
        end
        apb(1'b0, `OFS_MODE_CTRL, 32'h0);
        check("no overflow", 32'hC, rdv);
        $display("interval done");
    endtask
    task automatic t_event();
        logic [1:0] code [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
        logic [31:0] expv [4] = '{32'h5, 32'hA, 32'h0, 32'h5};
        int seen;
        for (int i = 0; i < 4; i++) begin
            start(8'h00, 16'h00FF, {code[i], 4'h3}, 8'h0C);
            pulse(1'b0, 8'h04, 8'h05);
            idle();
            apb(1'b0, `OFS_UP_COUNTER, 32'h0);
            check("event count", expv[i], rdv);
        end
        pulse(1'b0, 8'h01, 8'h03);
        idle();
        apb(1'b0, `OFS_UP_COUNTER, 32'h0);
        check("glitches ignored", 32'h5, rdv);
        start(8'h00, 16'h0003, 8'h13, 8'h0C);
        seen = n_irq_a;
        pulse(1'b0, 8'h04, 8'h08);
        idle();
        check("event matches", 32'h2, 32'(n_irq_a - seen));
        apb(1'b0, `OFS_UP_COUNTER, 32'h0);
        check("count after match", 32'h0, rdv);
        $display("event done");
    endtask
    // A pulse well under one counter period is timed from the captures at both of its edges.
    task automatic t_capture();
        logic [31:0] v1;
        logic [11:0] ad;
        int n;
        start(8'h05, 16'h0000, 8'hF0, 8'h04);
        for (int s = 0; s < 2; s++) begin
            ad = s ? `OFS_CMP_CAP_A : `OFS_CMP_CAP_B;
            pulse(s[0], 8'h28, 8'h01);
            wait_irq(!s[0], 200, n);
            apb(1'b0, ad, 32'h0);
            v1 = rdv;
            wait_irq(!s[0], 200, n);
            apb(1'b0, ad, 32'h0);
            check("pulse width", 32'h28, (rdv - v1) & 32'hFFFF);
            idle();
        end
        $display("capture done");
    endtask
    // Lowering the compare below the count sends the counter through a wrap first.
    task automatic t_lower();
        int n;
        start(8'h00, 16'h0040, 8'h00, 8'h0C);
        repeat (40) @(posedge clk_sys_in);
        apb(1'b1, `OFS_CMP_CAP_A, 32'h10);
        wait_irq(1'b0, 70000, n);
        check("match after wrap", 32'h1, 32'(n > 60000));
        apb(1'b0, `OFS_MODE_CTRL, 32'h0);
        check("overflow on wrap", 32'hD, rdv);
        $display("lower compare done");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        t_registers();
        t_interval();
        t_event();
        t_capture();
        t_lower();
        summarize();
    end
endmodule // testbench
